// ==== core/usb_rx_dma_regs.vh ====
// Summary of operation
// - Head pointer in bits 31:2, low bits zero
// - First descriptor pointer of current packet, bits 31:2
// - Bit 0 flags engine inside a packet
// - Active descriptor pointer bits 31:2, low zero
// - Full 32-bit byte address of next byte
// - Packet length upper half, written back at end
// - Lower half gives free bytes in buffer
`ifndef USB_RX_DMA_REGS_VH
`define USB_RX_DMA_REGS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFF_SKIP 8'h00
`define OFF_HEAD 8'h04
`define OFF_FIRST 8'h08
`define OFF_ACTIVE 8'h0c
`define OFF_BUFADDR 8'h10
`define OFF_LENGTH 8'h14
`define OFF_LENCOPY 8'h18
`define OFF_STATUS 8'h1c

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PTR_MSB 31
`define PTR_LSB 2
`define IN_PACKET_BIT 0
`define HALF_HI_MSB 31
`define HALF_HI_LSB 16
`define HALF_LO_MSB 15
`define HALF_LO_LSB 0
`define SKIP_MSB 7

// ------------------------------------------------------------
// Descriptor word offsets in memory
// ------------------------------------------------------------
`define DESC_NEXT 32'h0000_0000
`define DESC_BUF 32'h0000_0004
`define DESC_BUFLEN 32'h0000_0008
`define DESC_PKTLEN 32'h0000_000c

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_PTR 30'h0000_0000
`define RST_WORD 32'h0000_0000
`define RST_HALF 16'h0000
`define RST_SKIP 8'h00

`endif

// ==== core/rx_byte_fifo.v ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Byte FIFO between the receive stream and the DMA engine
// ------------------------------------------------------------
module rx_byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk, // Clock
  input wire rst_n, // Async reset, active low
  input wire in_valid, // Producer has a word
  input wire [WIDTH-1:0] in_data, // Producer word
  output reg in_ready, // Room for a word
  output reg out_valid, // A word is waiting
  output wire [WIDTH-1:0] out_data, // Oldest word
  input wire out_ready // Consumer takes the word
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  wire [AW:0] count_d;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = store[rd_ptr_q];

  // Storage has no reset; pointers, count and flags carry the state
  always @(posedge clk)
  begin
    if (push)
      store[wr_ptr_q] <= in_data;
  end

  // Flags are registered from the next count so both stay honest
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      count_q <= count_d;
      in_ready <= (count_d != DEPTH);
      out_valid <= (count_d != {(AW+1){1'b0}});
    end
  end

endmodule // rx_byte_fifo

`default_nettype wire

// ==== core/rx_dma_channel.v ====
`timescale 1ns/1ps
`default_nettype none
`include "usb_rx_dma_regs.vh"

// ------------------------------------------------------------
// Receive DMA channel: walks a descriptor queue, fills buffers
// ------------------------------------------------------------
module rx_dma_channel #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire pclk, // Clock, 250 MHz
  input wire presetn, // Async reset, active low
  input wire [7:0] paddr, // APB address
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped address
  input wire rx_valid, // Received byte valid
  input wire [7:0] rx_data, // Received byte
  input wire rx_last, // Byte ends the packet
  output wire rx_ready, // Byte taken when valid and ready
  output reg mem_req, // Memory request
  output reg mem_we, // Memory write
  output reg mem_byte, // Byte-wide write
  output reg [31:0] mem_addr, // Memory byte address
  output reg [31:0] mem_wdata, // Memory write data
  input wire mem_ack, // Memory done, one cycle
  input wire [31:0] mem_rdata // Read data, valid with ack
);

  // ------------------------------------------------------------
  // Engine states
  // ------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RD_BUF = 3'd1;
  localparam [2:0] S_RD_LEN = 3'd2;
  localparam [2:0] S_XFER = 3'd3;
  localparam [2:0] S_RD_NEXT = 3'd4;
  localparam [2:0] S_WR_LEN = 3'd5;
  localparam [2:0] S_RD_HEAD = 3'd6;
  localparam [2:0] S_STALL = 3'd7;

  // ------------------------------------------------------------
  // Channel state
  // ------------------------------------------------------------
  reg [2:0] state_q;
  reg [`SKIP_MSB:0] first_buffer_skip_bytes_q;
  reg [29:0] queue_head_pointer_q;
  reg [29:0] first_descriptor_pointer_q;
  reg in_packet_q;
  reg [29:0] active_descriptor_pointer_q;
  reg [31:0] active_buffer_address_q;
  reg [15:0] packet_byte_total_q;
  reg [15:0] buffer_free_bytes_q;
  reg first_buffer_q;
  reg starved_q;
  wire fifo_valid;
  wire [8:0] fifo_data;
  wire fifo_pop;
  wire done;
  wire [31:0] desc_base;
  wire [15:0] skip_ext;
  wire [15:0] buf_len_rd;
  wire [31:0] length_word;

  assign done = mem_req & mem_ack;
  assign desc_base = {active_descriptor_pointer_q, 2'b00};
  assign skip_ext = {8'h00, first_buffer_skip_bytes_q};
  assign buf_len_rd = mem_rdata[`HALF_LO_MSB:`HALF_LO_LSB];
  assign length_word = {packet_byte_total_q, buffer_free_bytes_q};
  // A byte leaves the FIFO only once its memory write is acknowledged
  assign fifo_pop = (state_q == S_XFER) & done;

  // ------------------------------------------------------------
  // Receive buffer; back-pressure reaches the source via rx_ready
  // ------------------------------------------------------------
  rx_byte_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(rx_valid),
    .in_data({rx_last, rx_data}),
    .in_ready(rx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire setup_ph;
  wire wr_take;
  wire sw_ok;
  reg hit;
  reg [31:0] rd_mux;

  assign setup_ph = psel & ~penable;
  assign wr_take = psel & penable & pready & pwrite & ~pslverr;
  // State words are only changed by software while the engine rests
  assign sw_ok = (state_q == S_IDLE) | (state_q == S_STALL);

  // Read mux; reserved bits read as zero
  always @*
  begin
    hit = 1'b1;
    rd_mux = `RST_WORD;
    if (paddr == `OFF_SKIP)
      rd_mux = {24'h000000, first_buffer_skip_bytes_q};
    else if (paddr == `OFF_HEAD)
      rd_mux = {queue_head_pointer_q, 2'b00};
    else if (paddr == `OFF_FIRST)
      rd_mux = {first_descriptor_pointer_q, 1'b0, in_packet_q};
    else if (paddr == `OFF_ACTIVE)
      rd_mux = {active_descriptor_pointer_q, 2'b00};
    else if (paddr == `OFF_BUFADDR)
      rd_mux = active_buffer_address_q;
    else if ((paddr == `OFF_LENGTH) | (paddr == `OFF_LENCOPY))
      rd_mux = length_word;
    else if (paddr == `OFF_STATUS)
      rd_mux = {27'h0000000, starved_q, 1'b0, state_q};
    else
      hit = 1'b0;
  end

  // One wait-free access phase: answer is prepared in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= `RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= (setup_ph & ~pwrite) ? rd_mux : `RST_WORD;
      pready <= setup_ph;
      pslverr <= setup_ph & ~hit;
    end
  end

  // ------------------------------------------------------------
  // Software view of the write strobes
  // ------------------------------------------------------------
  // Skip count is taken in any state; the rest only while resting
  wire wr_skip = wr_take & (paddr == `OFF_SKIP);
  wire wr_head = wr_take & sw_ok & (paddr == `OFF_HEAD);
  wire wr_first = wr_take & sw_ok & (paddr == `OFF_FIRST);
  wire wr_active = wr_take & sw_ok & (paddr == `OFF_ACTIVE);
  wire wr_bufaddr = wr_take & sw_ok & (paddr == `OFF_BUFADDR);
  // Both length words alias the same two counters
  wire wr_len = wr_take & sw_ok & ((paddr == `OFF_LENGTH) | (paddr == `OFF_LENCOPY));

  // Skip count is free to change; it only matters at packet start
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_buffer_skip_bytes_q <= `RST_SKIP;
    else if (wr_skip)
      first_buffer_skip_bytes_q <= pwdata[`SKIP_MSB:0];
  end

  // ------------------------------------------------------------
  // Memory request issue
  // ------------------------------------------------------------
  wire need_mem;

  // A new request starts the cycle after the previous one ends,
  // so address and data never change while a request is pending
  assign need_mem = ((state_q == S_RD_BUF) | (state_q == S_RD_LEN) |
                     (state_q == S_RD_NEXT) | (state_q == S_WR_LEN) |
                     (state_q == S_RD_HEAD) |
                     ((state_q == S_XFER) & fifo_valid &
                      (buffer_free_bytes_q != `RST_HALF))) & ~mem_req;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= `RST_WORD;
      mem_wdata <= `RST_WORD;
    end
    else if (done)
      mem_req <= 1'b0;
    else if (need_mem)
    begin
      mem_req <= 1'b1;
      mem_we <= (state_q == S_XFER) | (state_q == S_WR_LEN);
      mem_byte <= (state_q == S_XFER);
      mem_wdata <= `RST_WORD;
      if (state_q == S_RD_BUF)
        mem_addr <= desc_base + `DESC_BUF;
      else if (state_q == S_RD_LEN)
        mem_addr <= desc_base + `DESC_BUFLEN;
      else if (state_q == S_XFER)
      begin
        mem_addr <= active_buffer_address_q;
        mem_wdata <= {24'h000000, fifo_data[7:0]};
      end
      else if (state_q == S_WR_LEN)
      begin
        // Length lands in the low half of the first descriptor word 3
        mem_addr <= {first_descriptor_pointer_q, 2'b00} + `DESC_PKTLEN;
        mem_wdata <= {16'h0000, packet_byte_total_q};
      end
      else
        mem_addr <= desc_base + `DESC_NEXT;
    end
  end

  // ------------------------------------------------------------
  // Engine: descriptor walk and per-byte bookkeeping
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_IDLE;
      queue_head_pointer_q <= `RST_PTR;
      first_descriptor_pointer_q <= `RST_PTR;
      in_packet_q <= 1'b0;
      active_descriptor_pointer_q <= `RST_PTR;
      active_buffer_address_q <= `RST_WORD;
      packet_byte_total_q <= `RST_HALF;
      buffer_free_bytes_q <= `RST_HALF;
      first_buffer_q <= 1'b0;
      starved_q <= 1'b0;
    end
    else
    begin
      // Software writes reach the state words only while resting
      if (wr_head)
        queue_head_pointer_q <= pwdata[`PTR_MSB:`PTR_LSB];
      if (wr_first)
      begin
        first_descriptor_pointer_q <= pwdata[`PTR_MSB:`PTR_LSB];
        in_packet_q <= pwdata[`IN_PACKET_BIT];
      end
      if (wr_active)
        active_descriptor_pointer_q <= pwdata[`PTR_MSB:`PTR_LSB];
      if (wr_head | wr_active)
        starved_q <= 1'b0;
      if (wr_bufaddr)
        active_buffer_address_q <= pwdata;
      if (wr_len)
      begin
        packet_byte_total_q <= pwdata[`HALF_HI_MSB:`HALF_HI_LSB];
        buffer_free_bytes_q <= pwdata[`HALF_LO_MSB:`HALF_LO_LSB];
      end
      case (state_q)
        S_IDLE:
        begin
          // A waiting byte opens a packet at the queue head
          if (fifo_valid & ~wr_take)
          begin
            if (in_packet_q)
              state_q <= S_XFER;
            else if (queue_head_pointer_q == `RST_PTR)
              starved_q <= 1'b1;
            else
            begin
              first_descriptor_pointer_q <= queue_head_pointer_q;
              active_descriptor_pointer_q <= queue_head_pointer_q;
              in_packet_q <= 1'b1;
              packet_byte_total_q <= `RST_HALF;
              first_buffer_q <= 1'b1;
              state_q <= S_RD_BUF;
            end
          end
        end
        S_RD_BUF:
        begin
          if (done)
          begin
            // The first buffer starts after the software skip area
            active_buffer_address_q <= first_buffer_q ?
              mem_rdata + {24'h000000, first_buffer_skip_bytes_q} : mem_rdata;
            state_q <= S_RD_LEN;
          end
        end
        S_RD_LEN:
        begin
          if (done)
          begin
            // A skip larger than the buffer leaves no free room
            if (first_buffer_q & (buf_len_rd < skip_ext))
              buffer_free_bytes_q <= `RST_HALF;
            else if (first_buffer_q)
              buffer_free_bytes_q <= buf_len_rd - skip_ext;
            else
              buffer_free_bytes_q <= buf_len_rd;
            first_buffer_q <= 1'b0;
            state_q <= S_XFER;
          end
        end
        S_XFER:
        begin
          if (done)
          begin
            active_buffer_address_q <= active_buffer_address_q + 32'h0000_0001;
            buffer_free_bytes_q <= buffer_free_bytes_q - 16'h0001;
            packet_byte_total_q <= packet_byte_total_q + 16'h0001;
            if (fifo_data[8])
              state_q <= S_WR_LEN;
          end
          else if (~mem_req & (buffer_free_bytes_q == `RST_HALF) & fifo_valid)
            state_q <= S_RD_NEXT;
        end
        S_RD_NEXT:
        begin
          if (done)
          begin
            // End of chain inside a packet: wait for software
            if (mem_rdata[`PTR_MSB:`PTR_LSB] == `RST_PTR)
            begin
              starved_q <= 1'b1;
              state_q <= S_STALL;
            end
            else
            begin
              active_descriptor_pointer_q <= mem_rdata[`PTR_MSB:`PTR_LSB];
              state_q <= S_RD_BUF;
            end
          end
        end
        S_WR_LEN:
        begin
          if (done)
            state_q <= S_RD_HEAD;
        end
        S_RD_HEAD:
        begin
          // Queue head moves past the packet's last descriptor
          if (done)
          begin
            queue_head_pointer_q <= mem_rdata[`PTR_MSB:`PTR_LSB];
            in_packet_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default:
        begin
          // Stall ends when software supplies a new descriptor
          if (wr_active)
            state_q <= S_RD_BUF;
        end
      endcase
    end
  end

endmodule // rx_dma_channel

`default_nettype wire

// ==== test/rx_dma_checker_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------
// Port checker
// ----------
module rx_dma_checker #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic rx_valid, // Byte valid
  input wire logic [7:0] rx_data, // Byte
  input wire logic rx_last, // Last byte
  input wire logic rx_ready, // Byte taken
  input wire logic mem_req, // Memory request
  input wire logic mem_we, // Memory write
  input wire logic mem_byte, // Byte write
  input wire logic [31:0] mem_addr, // Memory address
  input wire logic [31:0] mem_wdata, // Memory data
  input wire logic mem_ack, // Memory done
  input wire logic [31:0] mem_rdata // Memory read data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Phases of a bus transfer and of a memory request
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  sequence mem_wait_s;
    mem_req && !mem_ack;
  endsequence

  // Register bus: one access cycle, answer stands one cycle
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no pready in first access cycle");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside one access cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  // Reserved pointer bits never read back as set
  head_low_zero_a:
    assert property (pready && !pwrite && paddr == 8'h04 |-> prdata[1:0] == 2'b00)
    else $error("head pointer low bits set");
  first_reserved_a:
    assert property (pready && !pwrite && paddr == 8'h08 |-> prdata[1] == 1'b0)
    else $error("first pointer bit 1 set");
  active_low_zero_a:
    assert property (pready && !pwrite && paddr == 8'h0c |-> prdata[1:0] == 2'b00)
    else $error("active pointer low bits set");
  // Memory requests hold until acknowledged, then drop
  req_hold_a: assert property (mem_wait_s |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  req_release_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after ack");
  len_write_a:
    assert property (mem_req && mem_we && !mem_byte |-> mem_wdata[31:16] == 16'h0)
    else $error("length write carries upper bits");
  desc_read_a: assert property (mem_req && !mem_we |-> mem_addr[1:0] == 2'b00)
    else $error("descriptor read not word aligned");
endmodule // rx_dma_checker

bind rx_dma_channel rx_dma_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) checker_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
  .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

`default_nettype wire

// ==== test/desc_memory.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------
// System memory with descriptors and buffers
// ----------
module desc_memory (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic mem_req, // Request
  input wire logic mem_we, // Write
  input wire logic mem_byte, // Byte write
  input wire logic [31:0] mem_addr, // Byte address
  input wire logic [31:0] mem_wdata, // Write data
  input wire logic [3:0] ack_delay, // Wait cycles before ack
  output logic mem_ack, // Done pulse
  output logic [31:0] mem_rdata // Read data
);
  logic [31:0] words [0:63];
  logic [3:0] wait_q;

  // Slow answers come from ack_delay; read data is garbled outside the ack
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= 32'h0;
    end
    else if (mem_ack || !mem_req)
    begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end
    else if (wait_q != ack_delay)
      wait_q <= wait_q + 4'h1;
    else
    begin
      mem_ack <= 1'b1;
      mem_rdata <= words[mem_addr[7:2]];
      if (mem_we && mem_byte)
        words[mem_addr[7:2]][8*mem_addr[1:0] +: 8] <= mem_wdata[7:0];
      else if (mem_we)
        words[mem_addr[7:2]] <= mem_wdata;
    end
  end
endmodule // desc_memory

`default_nettype wire

// ==== test/test_rx_dma_channel.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_rx_dma_channel;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rx_valid = 1'b0, rx_last = 1'b0, saw_full = 1'b0, err;
  logic [7:0] paddr = 8'h00, rx_data = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] ack_delay = 4'h0;
  wire logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
  wire logic pready, pslverr, rx_ready, mem_req, mem_we, mem_byte, mem_ack;
  int failures = 0, checks_done = 0, cycles = 0;
  typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} row_t;
  row_t rows [9] = '{'{8'h00, 32'hffff_ffff, 8'h00, 32'h0000_00ff},
    '{8'h04, 32'hffff_ffff, 8'h04, 32'hffff_fffc}, '{8'h08, 32'hffff_ffff, 8'h08, 32'hffff_fffd},
    '{8'h0c, 32'hffff_ffff, 8'h0c, 32'hffff_fffc}, '{8'h10, 32'ha5a5_5a5b, 8'h10, 32'ha5a5_5a5b},
    '{8'h14, 32'h1234_5678, 8'h18, 32'h1234_5678}, '{8'h18, 32'h0abc_0def, 8'h14, 32'h0abc_0def},
    '{8'h08, 32'h0000_0000, 8'h08, 32'h0000_0000}, '{8'h1c, 32'hffff_ffff, 8'h1c, 32'h0}};
  logic [31:0] dnext [3] = '{32'h50, 32'h60, 32'h0};
  logic [31:0] dbuf [3] = '{32'h80, 32'ha0, 32'hc0};
  logic [31:0] dlen [3] = '{32'h4, 32'h8, 32'h10};

  rx_dma_channel rx_dma_channel_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .mem_req(mem_req), .mem_we(mem_we),
    .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  desc_memory desc_memory_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .ack_delay(ack_delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Clock, 4 ns period
  always #2 pclk = ~pclk;

  // Hang guard and stall watch; a full FIFO must push back on the stream
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (rx_valid && rx_ready === 1'b0)
      saw_full <= 1'b1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] ex);
    checks_done++;
    if (got !== ex)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  // Bus transfer: held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q, ex);
  endtask

  // Stream a packet; each byte is held until rx_ready is seen
  task automatic send(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++)
    begin
      rx_valid <= 1'b1;
      rx_data <= base + i[7:0];
      rx_last <= (i == n - 1);
      @(posedge pclk);
      while (rx_ready !== 1'b1) @(posedge pclk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask

  // Poll engine state until it shows the given code
  task automatic wait_state(input logic [2:0] s);
    logic [31:0] q;
    logic e;
    q = {29'h0, ~s};
    while (q[2:0] !== s)
      apb(1'b0, 8'h1c, 32'h0, q, e);
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ----------
  // Main sequence
  // ----------
  initial
  begin
    for (int i = 0; i < 64; i++)
      desc_memory_inst.words[i] = 32'h0;
    for (int d = 0; d < 3; d++)
    begin
      desc_memory_inst.words[16 + 4 * d] = dnext[d];
      desc_memory_inst.words[17 + 4 * d] = dbuf[d];
      desc_memory_inst.words[18 + 4 * d] = dlen[d];
    end
    do_reset;
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rdchk(rows[i].ra, rows[i].ex);
    end
    apb(1'b1, 8'h20, 32'h1, rd, err);
    cmp({31'h0, err}, 32'h1);
    apb(1'b0, 8'h24, 32'h0, rd, err);
    cmp({rd[31:1], err}, 32'h1);
    do_reset;
    for (int a = 0; a < 32; a += 4)
      rdchk(a[7:0], 32'h0);
    // Packet over two buffers, prompt memory
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h40);
    send(6, 8'h10);
    wait_state(3'h0);
    cmp(desc_memory_inst.words[32], 32'h1110_0000);
    cmp(desc_memory_inst.words[40], 32'h1514_1312);
    cmp(desc_memory_inst.words[19], 32'h6);
    rdchk(8'h04, 32'h60);
    rdchk(8'h08, 32'h40);
    rdchk(8'h0c, 32'h50);
    rdchk(8'h10, 32'ha4);
    rdchk(8'h14, 32'h0006_0004);
    // Slow memory: FIFO fills and stream stalls
    ack_delay <= 4'h6;
    send(10, 8'h20);
    rdchk(8'h08, 32'h61);
    wait_state(3'h0);
    cmp(desc_memory_inst.words[48], 32'h2120_0000);
    cmp(desc_memory_inst.words[49], 32'h2524_2322);
    cmp(desc_memory_inst.words[50], 32'h2928_2726);
    cmp(desc_memory_inst.words[27], 32'ha);
    rdchk(8'h04, 32'h0);
    rdchk(8'h18, 32'h000a_0004);
    cmp({31'h0, saw_full}, 32'h1);
    // Starved start on an empty head, then a stall resumed by software
    wr(8'h00, 32'hf);
    send(2, 8'h30);
    rdchk(8'h1c, 32'h10);
    wr(8'h04, 32'h60);
    wait_state(3'h7);
    rdchk(8'h1c, 32'h17);
    wr(8'h0c, 32'h40);
    wait_state(3'h0);
    cmp(desc_memory_inst.words[51], 32'h3000_0000);
    cmp(desc_memory_inst.words[32], 32'h1110_0031);
    cmp(desc_memory_inst.words[27], 32'h2);
    rdchk(8'h04, 32'h50);
    rdchk(8'h14, 32'h0002_0003);
    stop_test;
  end
endmodule // test_rx_dma_channel

`default_nettype wire
